//--- logic/bmn_pkg.sv
/*
 * Package for the byte multiply / negate execution datapath.
 * Holds opcode patterns, register offsets, address layout,
 * status bit positions and the phase and operation enumerations.
 * Assumes a single 250 MHz core clock and one instruction per
 * four clock phases.
 */
package bmn_pkg;

    // ------------------------------------------------------------
    // Opcode patterns
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_MUL_LIT  = 8'h0D;  // Literal multiply
    localparam logic [6:0] OPC_MUL_FILE = 7'h01;  // File multiply, a in bit 8
    localparam logic [6:0] OPC_NEG_FILE = 7'h36;  // Negate file, a in bit 8
    localparam logic [3:0] OPC_NOP_HI   = 4'hF;   // Second-word no-op nibble
    localparam logic [15:0] OPC_NOP     = 16'h0000;

    // ------------------------------------------------------------
    // Data memory layout
    // ------------------------------------------------------------
    localparam int          MEM_DEPTH    = 4096;   // Sixteen banks of 256 bytes
    localparam logic [7:0]  ACC_SPLIT    = 8'h60;  // First high access-bank offset
    localparam logic [7:0]  IDX_LIMIT    = 8'h5F;  // Highest indexed offset
    localparam logic [3:0]  ACC_HI_BANK  = 4'hF;   // Bank of upper access half
    localparam logic [3:0]  ACC_LO_BANK  = 4'h0;   // Bank of lower access half

    // ------------------------------------------------------------
    // Register port map (byte data, 13-bit address)
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 13;
    localparam logic [12:0] REG_BASE     = 13'h1000;  // Below: data memory
    localparam logic [12:0] REG_WORK     = 13'h1000;  // Working register
    localparam logic [12:0] REG_BANK     = 13'h1001;  // bank_select_reg
    localparam logic [12:0] REG_PROD_LO  = 13'h1002;  // product_low_reg
    localparam logic [12:0] REG_PROD_HI  = 13'h1003;  // product_high_reg
    localparam logic [12:0] REG_STATUS   = 13'h1004;  // Status flags
    localparam logic [12:0] REG_CTRL     = 13'h1005;  // Control
    localparam logic [12:0] REG_IDX_LO   = 13'h1006;  // Index base, low byte
    localparam logic [12:0] REG_IDX_HI   = 13'h1007;  // Index base, high nibble

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          CTRL_EXT_BIT = 0;      // Extended set enable
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [3:0]  RST_NIB      = 4'h0;
    localparam logic [11:0] RST_IDX      = 12'h000;

    // Status flags as stored, bit 4 down to bit 0
    typedef struct packed {
        logic neg;   // Negative
        logic ovf;   // overflow_flag
        logic zero;  // Zero
        logic dcy;   // digit_carry_flag
        logic cy;    // Carry
    } bmn_flags_s;

    localparam bmn_flags_s RST_FLAGS = '{default: 1'b0};

    // Instruction phases
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bmn_phase_e;

    // Decoded operation
    typedef enum logic [1:0] {OP_NONE, OP_MULL, OP_MULF, OP_NEGATE_FILE_OP} bmn_op_e;

endpackage

//--- logic/bmn_exec.sv
/*
 * Execution datapath for the literal multiply, file multiply,
 * file negate and no-operation instructions, with its own data
 * memory and a byte-wide software register port.
 * Assumes the instruction word on i_INSTR is synchronous to
 * I_REF_CLK and is sampled on the edge that closes phase Q1.
 */
`timescale 1ns/100ps

module bmn_exec
(
    // Clock and reset
    input  wire logic                      I_REF_CLK,
    input  wire logic                      I_RST_B,
    // Instruction
    input  wire logic [15:0]               I_INSTR,
    // Register port
    input  wire logic [bmn_pkg::ADDR_W-1:0] I_ADDR,
    input  wire logic [7:0]                I_WDATA,
    input  wire logic                      I_WR,
    input  wire logic                      I_RD,
    output logic      [7:0]                O_RDATA,
    // Execution state
    output logic                           O_RETIRE,
    output logic      [15:0]               O_PROD,
    output bmn_pkg::bmn_flags_s            O_FLAGS
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bmn_pkg::bmn_phase_e phase;          // Current phase
    bmn_pkg::bmn_op_e    op;             // Operation in flight
    logic [15:0]         ir;             // Latched instruction
    logic [11:0]         ea;             // Operand byte address
    logic [7:0]          opnd;           // Operand read in Q2
    logic [15:0]         prod_res;       // Product from Q3
    logic [7:0]          neg_res;        // Negate result from Q3
    bmn_pkg::bmn_flags_s neg_flags;      // Negate flags from Q3
    logic [7:0]          work;           // Working register
    logic [3:0]          bank;           // bank_select_reg, upper nibble zero
    logic [7:0]          prod_lo;        // product_low_reg
    logic [7:0]          prod_hi;        // product_high_reg
    bmn_pkg::bmn_flags_s flags;          // Status flags
    logic                ext_en;         // Extended set enable
    logic [11:0]         idx_base;       // Index base for offset mode
    logic [7:0]          mem [bmn_pkg::MEM_DEPTH]; // Data memory

    bmn_pkg::bmn_op_e    next_op;        // Decode of I_INSTR
    logic [11:0]         next_ea;        // Address formed from ir
    logic [8:0]          neg_sum;        // Complement plus one, with carry
    logic [4:0]          neg_nib;        // Low nibble sum, with carry
    logic                bus_mem;        // Port address hits memory
    logic                wr_work;        // Port writes the working register
    logic                wr_status;      // Port writes the status register

    assign bus_mem   = (I_ADDR < bmn_pkg::REG_BASE);
    assign wr_work   = I_WR && (I_ADDR == bmn_pkg::REG_WORK);
    assign wr_status = I_WR && (I_ADDR == bmn_pkg::REG_STATUS);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Sort the incoming word into one of the handled operations
    always_comb
    begin
        if (I_INSTR == bmn_pkg::OPC_NOP || I_INSTR[15:12] == bmn_pkg::OPC_NOP_HI)
        begin
            next_op = bmn_pkg::OP_NONE;
        end
        else if (I_INSTR[15:8] == bmn_pkg::OPC_MUL_LIT)
        begin
            next_op = bmn_pkg::OP_MULL;
        end
        else if (I_INSTR[15:9] == bmn_pkg::OPC_MUL_FILE)
        begin
            next_op = bmn_pkg::OP_MULF;
        end
        else if (I_INSTR[15:9] == bmn_pkg::OPC_NEG_FILE)
        begin
            next_op = bmn_pkg::OP_NEGATE_FILE_OP;
        end
        // Words outside this group pass as no-ops
        else
        begin
            next_op = bmn_pkg::OP_NONE;
        end
    end

    // Form the operand address from bank bit and offset
    always_comb
    begin
        // bank bit set, bank register supplies the bank
        if (ir[8])
        begin
            next_ea = {bank, ir[7:0]};
        end
        else if (ext_en && ir[7:0] <= bmn_pkg::IDX_LIMIT)
        begin
            next_ea = idx_base + {4'h0, ir[7:0]};
        end
        else if (ir[7:0] < bmn_pkg::ACC_SPLIT)
        begin
            next_ea = {bmn_pkg::ACC_LO_BANK, ir[7:0]};
        end
        // Access bank, upper half maps to the top bank
        else
        begin
            next_ea = {bmn_pkg::ACC_HI_BANK, ir[7:0]};
        end
    end

    // Two's-complement sums for the negate result and its carries
    assign neg_sum = {1'b0, ~opnd} + 9'h001;
    assign neg_nib = {1'b0, ~opnd[3:0]} + 5'h01;

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    // Q1 to Q4 then back, every instruction four cycles
    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            phase <= bmn_pkg::PH_Q1;
        end
        else
        begin
            case (phase)
                bmn_pkg::PH_Q1: phase <= bmn_pkg::PH_Q2;
                bmn_pkg::PH_Q2: phase <= bmn_pkg::PH_Q3;
                bmn_pkg::PH_Q3: phase <= bmn_pkg::PH_Q4;
                default:        phase <= bmn_pkg::PH_Q1;
            endcase
        end
    end

    // Q1: latch and decode the instruction word
    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ir <= bmn_pkg::OPC_NOP;
            op <= bmn_pkg::OP_NONE;
        end
        else if (phase == bmn_pkg::PH_Q1)
        begin
            ir <= I_INSTR;
            op <= next_op;
        end
    end

    // Q2: fix the address and read the operand byte
    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ea   <= 12'h000;
            opnd <= bmn_pkg::RST_BYTE;
        end
        else if (phase == bmn_pkg::PH_Q2)
        begin
            ea <= next_ea;
            // Literal multiply takes the literal, others the file byte
            if (op == bmn_pkg::OP_MULL)
            begin
                opnd <= ir[7:0];
            end
            else
            begin
                opnd <= mem[next_ea];
            end
        end
    end

    // Q3: compute product, negate result and negate flags
    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            prod_res  <= 16'h0000;
            neg_res   <= bmn_pkg::RST_BYTE;
            neg_flags <= bmn_pkg::RST_FLAGS;
        end
        else if (phase == bmn_pkg::PH_Q3)
        begin
            prod_res       <= {8'h00, work} * {8'h00, opnd};
            neg_res        <= neg_sum[7:0];
            neg_flags.neg  <= neg_sum[7];
            neg_flags.ovf  <= (opnd == 8'h80);
            neg_flags.zero <= (neg_sum[7:0] == 8'h00);
            neg_flags.dcy  <= neg_nib[4];
            neg_flags.cy   <= neg_sum[8];
        end
    end

    // ------------------------------------------------------------
    // Q4 write-back and software writes
    // ------------------------------------------------------------
    // Product pair; the instruction wins over a port write in Q4
    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            prod_lo <= bmn_pkg::RST_BYTE;
            prod_hi <= bmn_pkg::RST_BYTE;
        end
        // high byte to high register, low to low
        else if (phase == bmn_pkg::PH_Q4 &&
                 (op == bmn_pkg::OP_MULL || op == bmn_pkg::OP_MULF))
        begin
            prod_hi <= prod_res[15:8];
            prod_lo <= prod_res[7:0];
        end
        else if (I_WR && I_ADDR == bmn_pkg::REG_PROD_LO)
        begin
            prod_lo <= I_WDATA;
        end
        else if (I_WR && I_ADDR == bmn_pkg::REG_PROD_HI)
        begin
            prod_hi <= I_WDATA;
        end
    end

    // Status flags; multiplies never reach this register
    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            flags <= bmn_pkg::RST_FLAGS;
        end
        else if (phase == bmn_pkg::PH_Q4 && op == bmn_pkg::OP_NEGATE_FILE_OP)
        begin
            flags <= neg_flags;
        end
        // port write only; no multiply path here
        else if (wr_status)
        begin
            flags <= I_WDATA[4:0];
        end
    end

    // Working register, bank, control and index base: port only
    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            work     <= bmn_pkg::RST_BYTE;
            bank     <= bmn_pkg::RST_NIB;
            ext_en   <= 1'b0;
            idx_base <= bmn_pkg::RST_IDX;
        end
        else if (I_WR)
        begin
            case (I_ADDR)
                // only software changes the working register
                bmn_pkg::REG_WORK:   work            <= I_WDATA;
                bmn_pkg::REG_BANK:   bank            <= I_WDATA[3:0];
                bmn_pkg::REG_CTRL:   ext_en          <= I_WDATA[bmn_pkg::CTRL_EXT_BIT];
                bmn_pkg::REG_IDX_LO: idx_base[7:0]   <= I_WDATA;
                bmn_pkg::REG_IDX_HI: idx_base[11:8]  <= I_WDATA[3:0];
                default:             work            <= work;
            endcase
        end
    end

    // Data memory; negate write-back wins over a port write
    always_ff @(posedge I_REF_CLK)
    begin
        // result back to the same location
        if (phase == bmn_pkg::PH_Q4 && op == bmn_pkg::OP_NEGATE_FILE_OP)
        begin
            mem[ea] <= neg_res;
        end
        else if (I_WR && bus_mem)
        begin
            mem[I_ADDR[11:0]] <= I_WDATA;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            O_RDATA <= bmn_pkg::RST_BYTE;
        end
        else if (!I_RD)
        begin
            O_RDATA <= bmn_pkg::RST_BYTE;
        end
        else if (bus_mem)
        begin
            O_RDATA <= mem[I_ADDR[11:0]];
        end
        else
        begin
            case (I_ADDR)
                bmn_pkg::REG_WORK:    O_RDATA <= work;
                bmn_pkg::REG_BANK:    O_RDATA <= {4'h0, bank};
                bmn_pkg::REG_PROD_LO: O_RDATA <= prod_lo;
                bmn_pkg::REG_PROD_HI: O_RDATA <= prod_hi;
                bmn_pkg::REG_STATUS:  O_RDATA <= {3'h0, flags};
                bmn_pkg::REG_CTRL:    O_RDATA <= {7'h00, ext_en};
                bmn_pkg::REG_IDX_LO:  O_RDATA <= idx_base[7:0];
                bmn_pkg::REG_IDX_HI:  O_RDATA <= {4'h0, idx_base[11:8]};
                default:              O_RDATA <= bmn_pkg::RST_BYTE;
            endcase
        end
    end

    // Retire pulse, product and flag mirrors
    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            O_RETIRE <= 1'b0;
            O_PROD   <= 16'h0000;
            O_FLAGS  <= bmn_pkg::RST_FLAGS;
        end
        else
        begin
            O_RETIRE <= (phase == bmn_pkg::PH_Q4);
            O_PROD   <= {prod_hi, prod_lo};
            O_FLAGS  <= flags;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B);

    // Sampled reset keeps the attempt on the release edge out, where the
    // sequencer was still held in Q1 although the disable is already off
    phase_cycle_a: assert property (I_RST_B && phase == bmn_pkg::PH_Q1 |=>
        phase == bmn_pkg::PH_Q2 ##1 phase == bmn_pkg::PH_Q3
        ##1 phase == bmn_pkg::PH_Q4 ##1 phase == bmn_pkg::PH_Q1)
        else $error("phase sequence broken");

    lit_product_a: assert property ((phase == bmn_pkg::PH_Q1 &&
        I_INSTR[15:8] == bmn_pkg::OPC_MUL_LIT && !wr_work) ##1 !wr_work[*2]
        |=> ##1 {prod_hi, prod_lo} == {8'h00, $past(work, 2)} * {8'h00, $past(ir[7:0], 2)})
        else $error("literal product wrong");

    prod_split_a: assert property ((phase == bmn_pkg::PH_Q4 &&
        (op == bmn_pkg::OP_MULL || op == bmn_pkg::OP_MULF))
        |=> prod_hi == $past(prod_res[15:8]) && prod_lo == $past(prod_res[7:0]))
        else $error("product pair not loaded");

    mul_keep_a: assert property ((phase == bmn_pkg::PH_Q4 &&
        op != bmn_pkg::OP_NEGATE_FILE_OP && !wr_status && !wr_work)
        |=> $stable(flags) && $stable(work))
        else $error("multiply touched flags or working register");

    file_product_a: assert property ((phase == bmn_pkg::PH_Q2 &&
        op == bmn_pkg::OP_MULF && !I_WR) ##1 !wr_work
        |=> ##1 {prod_hi, prod_lo} == {8'h00, $past(work)} * {8'h00, $past(opnd)})
        else $error("file product wrong");

    access_bank_a: assert property ((phase == bmn_pkg::PH_Q2 && !ir[8] &&
        !(ext_en && ir[7:0] <= bmn_pkg::IDX_LIMIT))
        |=> ea[7:0] == $past(ir[7:0]) && ea[11:8] ==
        ($past(ir[7:0]) < bmn_pkg::ACC_SPLIT ? bmn_pkg::ACC_LO_BANK : bmn_pkg::ACC_HI_BANK))
        else $error("access bank address wrong");

    bank_select_a: assert property ((phase == bmn_pkg::PH_Q2 && ir[8])
        |=> ea == {$past(bank), $past(ir[7:0])})
        else $error("banked address wrong");

    indexed_addr_a: assert property ((phase == bmn_pkg::PH_Q2 && !ir[8] &&
        ext_en && ir[7:0] <= bmn_pkg::IDX_LIMIT)
        |=> ea == $past(idx_base) + {4'h0, $past(ir[7:0])})
        else $error("indexed address wrong");

    neg_write_a: assert property ((phase == bmn_pkg::PH_Q3 &&
        op == bmn_pkg::OP_NEGATE_FILE_OP) ##1 1'b1
        |=> mem[$past(ea)] == 8'(8'h00 - $past(opnd, 2)))
        else $error("negate result wrong");

    neg_flags_a: assert property ((phase == bmn_pkg::PH_Q3 &&
        op == bmn_pkg::OP_NEGATE_FILE_OP) ##1 1'b1
        |=> flags.zero == ($past(opnd, 2) == 8'h00) && flags.cy == flags.zero
        && flags.ovf == ($past(opnd, 2) == 8'h80))
        else $error("negate flags wrong");

    nop_quiet_a: assert property ((phase == bmn_pkg::PH_Q4 &&
        op == bmn_pkg::OP_NONE && !I_WR)
        |=> $stable(flags) && $stable(prod_lo) && $stable(prod_hi))
        else $error("no-op changed state");

    lit_mul_c:  cover property (phase == bmn_pkg::PH_Q4 && op == bmn_pkg::OP_MULL);
    file_mul_c: cover property (phase == bmn_pkg::PH_Q4 && op == bmn_pkg::OP_MULF);
    neg_zero_c: cover property (phase == bmn_pkg::PH_Q4 && op == bmn_pkg::OP_NEGATE_FILE_OP
                                && neg_flags.zero);
    indexed_c:  cover property (phase == bmn_pkg::PH_Q2 && !ir[8] && ext_en
                                && ir[7:0] <= bmn_pkg::IDX_LIMIT);

endmodule

//--- dv/bmn_exec_tb.sv
/*
 * Self-checking bench for bmn_exec: multiply, negate and no-op slots
 * driven with random operands, observed through the register port and the product, flag and retire outputs.
 * Assumes the four-phase cycle restarts at the first edge after reset.
 */
`timescale 1ns/100ps

module bmn_exec_tb;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                clk        = 1'b0;    // 250 MHz clock
    logic                rst_b      = 1'b0;    // Reset, active low
    logic [15:0]         instr      = 16'h0000;
    logic [12:0]         addr       = 13'h0000;
    logic [7:0]          wdata      = 8'h00;
    logic                wr         = 1'b0;
    logic                rd         = 1'b0;
    logic [7:0]          rdata;
    logic                retire;
    logic [15:0]         prod;
    bmn_pkg::bmn_flags_s flags;
    int                  fail_count = 0;       // Mismatches
    int                  checked    = 0;       // Comparisons
    int                  ph         = 0;       // Edges since slot start
    logic [7:0]          w, k, v, r, f;        // Operands and read-back
    logic [3:0]          bank;
    logic [11:0]         idx, loc;
    logic [4:0]          st;                   // Preset status
    logic [15:0]         p;
    logic                acc, ext;

    bmn_exec dut
    (
        .I_REF_CLK (clk),
        .I_RST_B   (rst_b),
        .I_INSTR   (instr),
        .I_ADDR    (addr),
        .I_WDATA   (wdata),
        .I_WR      (wr),
        .I_RD      (rd),
        .O_RDATA   (rdata),
        .O_RETIRE  (retire),
        .O_PROD    (prod),
        .O_FLAGS   (flags)
    );

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        forever #2 clk = ~clk;
    end

    initial
    begin
        repeat (30000) @(posedge clk);
        fail_count++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Tasks and models
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One edge, keeping the slot phase
    task automatic tick();
        @(posedge clk);
        ph = (ph + 1) % 4;
    endtask

    // Port write; the strobe stays up until the next request
    task automatic put(input logic [12:0] a, input logic [7:0] d);
        instr <= bmn_pkg::OPC_NOP;
        addr  <= a;
        wdata <= d;
        rd    <= 1'b0;
        wr    <= 1'b1;
        tick();
    endtask

    // Port read; data taken in the cycle after the strobe
    task automatic get(input logic [12:0] a, output logic [7:0] d);
        instr <= bmn_pkg::OPC_NOP;
        addr  <= a;
        wr    <= 1'b0;
        rd    <= 1'b1;
        tick();
        #1;
        d = rdata;
    endtask

    // One instruction slot, aligned to Q1, port idle meanwhile
    task automatic run(input logic [15:0] op);
        wr <= 1'b0;
        rd <= 1'b0;
        if (ph != 0)
        begin
            instr <= bmn_pkg::OPC_NOP;
            while (ph != 0) tick();
        end
        instr <= op;
        repeat (3) tick();
        #1;
        check(retire, 1'b0);
        tick();
        #1;
        check(retire, 1'b1);
    endtask

    // Effective data address of a file operand
    function automatic logic [11:0] ea(input logic a, input logic [7:0] fa,
                                       input logic [3:0] b, input logic x,
                                       input logic [11:0] base);
        if (a)
            return {b, fa};
        if (x && fa <= 8'h5F)
            return base + {4'h0, fa};
        return {(fa < 8'h60) ? 4'h0 : 4'hF, fa};
    endfunction

    // Flags after negation: neg, ovf, zero, dcy, cy
    function automatic logic [4:0] nflags(input logic [7:0] x);
        logic [7:0] n;
        n = ~x + 8'h01;
        return {n[7], x == 8'h80, n == 8'h00, x[3:0] == 4'h0, x == 8'h00};
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h49B0154E));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values, then one unmapped place
        for (int i = 0; i < 9; i++)
        begin
            get(bmn_pkg::REG_BASE + 13'(i), r);
            check(r, 8'h00);
        end
        put(13'h1FFF, 8'hA5);
        get(13'h1FFF, r);
        check(r, 8'h00);
        // Literal multiply: example, zero product, all ones, random
        st = 5'h0B;
        put(bmn_pkg::REG_STATUS, {3'h0, st});
        for (int i = 0; i < 24; i++)
        begin
            w = (i == 0) ? 8'hE2 : (i == 1) ? 8'h00 : (i == 2) ? 8'hFF : 8'($urandom);
            k = (i == 0) ? 8'hC4 : (i == 2) ? 8'hFF : 8'($urandom);
            p = 16'(w) * 16'(k);
            put(bmn_pkg::REG_WORK, w);
            run({bmn_pkg::OPC_MUL_LIT, k});
            get(bmn_pkg::REG_PROD_HI, r);
            check(r, p[15:8]);
            get(bmn_pkg::REG_PROD_LO, r);
            check(r, p[7:0]);
            get(bmn_pkg::REG_WORK, r);
            check(r, w);
            check(prod, p);
            check({11'h000, flags}, {11'h000, st});
        end
        // File multiply and negate over every addressing mode
        for (int i = 0; i < 48; i++)
        begin
            acc  = (i < 16) ? i[2] : 1'($urandom);
            ext  = (i < 16) ? i[3] : 1'($urandom);
            f    = (i < 16) ? (i[0] ? 8'h5F : 8'h60) : 8'($urandom);
            v    = (i % 5 == 0) ? 8'h00 : (i % 5 == 1) ? 8'h80 : 8'($urandom);
            v    = (i == 2) ? 8'h3A : v;
            bank = 4'($urandom);
            idx  = 12'($urandom % 3584);
            w    = 8'($urandom);
            loc  = ea(acc, f, bank, ext, idx);
            put(bmn_pkg::REG_BANK, {4'h0, bank});
            put(bmn_pkg::REG_CTRL, {7'h00, ext});
            put(bmn_pkg::REG_IDX_LO, idx[7:0]);
            put(bmn_pkg::REG_IDX_HI, {4'h0, idx[11:8]});
            put({1'b0, loc}, v);
            put(bmn_pkg::REG_WORK, w);
            put(bmn_pkg::REG_STATUS, {3'h0, st});
            run({i[1] ? bmn_pkg::OPC_NEG_FILE : bmn_pkg::OPC_MUL_FILE, acc, f});
            get({1'b0, loc}, r);
            if (i[1])
            begin
                check(r, 8'(-v));
                check({11'h000, flags}, {11'h000, nflags(v)});
            end
            else
            begin
                check(r, v);
                get(bmn_pkg::REG_WORK, r);
                check(r, w);
                check(prod, 16'(w) * 16'(v));
                check({11'h000, flags}, {11'h000, st});
            end
        end
        // No-op words leave everything alone
        put(13'h0123, 8'h5A);
        put(bmn_pkg::REG_STATUS, {3'h0, st});
        put(bmn_pkg::REG_WORK, 8'h37);
        run({bmn_pkg::OPC_MUL_LIT, 8'h91});
        p = 16'h37 * 16'h91;
        for (int i = 0; i < 6; i++)
        begin
            run((i == 0) ? bmn_pkg::OPC_NOP : {bmn_pkg::OPC_NOP_HI, 12'($urandom)});
            check(prod, p);
            check({11'h000, flags}, {11'h000, st});
        end
        get(13'h0123, r);
        check(r, 8'h5A);
        get(bmn_pkg::REG_WORK, r);
        check(r, 8'h37);
        finish_test();
    end

endmodule
